// ===== core/pll_clock_module.sv
`timescale 1ns/1ps
`default_nettype none

module pll_clock_module #(
	parameter int unsigned SETTLE_CYCLES = pll_clock_pkg::PLL_SETTLE_CYCLES
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// register port
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// processor write protection
	input  wire logic        write_protect_override,
	// oscillator presence, from the pad
	input  wire logic        oscillator_present,
	// clock control
	output logic      [1:0]  pll_mode,
	output logic      [3:0]  pll_multiplier,
	output logic             core_halving_select,
	output logic             pll_powered,
	output logic             pll_lock_flag,
	output logic             cpu_input_clock_en,
	output logic             system_clock_output_en,
	output logic             limp_select,
	// peripheral clock settings
	output logic      [15:0] fast_peripheral_prescaler,
	output logic      [15:0] slow_peripheral_prescaler,
	output logic      [15:0] peripheral_clock_gate_0,
	output logic      [15:0] peripheral_clock_gate_1
);

	// register write decode
	logic wr_ok;
	logic mult_wr;
	logic status_wr;

	// stored registers
	logic [15:0] clkout_status_q;
	logic [15:0] fast_prescale_q;
	logic [15:0] slow_prescale_q;
	logic [15:0] clk_gate0_q;
	logic [15:0] clk_gate1_q;
	logic [3:0]  mult_q;
	logic        halving_q;
	logic        disable_q;
	logic        lock_q;

	// mode and outputs
	pll_clock_pkg::pll_mode_t mode_d;
	pll_clock_pkg::pll_mode_t mode_q;
	logic [3:0]  eff_mult_q;
	logic        powered_q;
	logic        cpu_tick_q;
	logic        sys_tick_q;
	logic [15:0] rdata_d;
	logic [15:0] rdata_q;

	// oscillator presence synchroniser and limp detection
	logic osc_meta_q;
	logic osc_sync_q;
	logic osc_seen_q;
	logic limp_q;

	// helpers
	logic settle_done;
	logic ref_tick;
	logic [15:0] status_word;

	assign wr_ok     = reg_wr & write_protect_override;
	// reserved codes are dropped whole, so they never start a relock
	assign mult_wr   = wr_ok && (reg_addr == pll_clock_pkg::OFF_PLL_MULT)
		&& (reg_wdata[3:0] <= pll_clock_pkg::MULT_MAX);
	assign status_wr = wr_ok && (reg_addr == pll_clock_pkg::OFF_PLL_STATUS);

	// plain configuration words
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			clkout_status_q <= pll_clock_pkg::RST_WORD;
			fast_prescale_q <= pll_clock_pkg::RST_WORD;
			slow_prescale_q <= pll_clock_pkg::RST_WORD;
			clk_gate0_q     <= pll_clock_pkg::RST_WORD;
			clk_gate1_q     <= pll_clock_pkg::RST_WORD;
		end else if (wr_ok) begin
			unique case (reg_addr)
				pll_clock_pkg::OFF_CLKOUT_STATUS: begin
					clkout_status_q <= reg_wdata;
				end
				pll_clock_pkg::OFF_FAST_PRESCALE: begin
					fast_prescale_q <= reg_wdata;
				end
				pll_clock_pkg::OFF_SLOW_PRESCALE: begin
					slow_prescale_q <= reg_wdata;
				end
				pll_clock_pkg::OFF_CLK_GATE_0: begin
					clk_gate0_q <= reg_wdata;
				end
				pll_clock_pkg::OFF_CLK_GATE_1: begin
					clk_gate1_q <= reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// multiplier, reset to bypass
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			mult_q <= pll_clock_pkg::RST_MULT;
		end else if (mult_wr) begin
			mult_q <= reg_wdata[3:0];
		end
	end

	// halving select and pll disable; ordering against the multiplier
	// is left to software, the hardware takes each write as it comes
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			halving_q <= pll_clock_pkg::RST_HALVING;
			disable_q <= pll_clock_pkg::RST_DISABLE;
		end else if (status_wr) begin
			halving_q <= reg_wdata[pll_clock_pkg::STS_HALVING_BIT];
			disable_q <= reg_wdata[pll_clock_pkg::STS_DISABLE_BIT];
		end
	end

	pll_settle_timer #(
		.CYCLES (SETTLE_CYCLES)
	) u_settle (
		.core_clk (core_clk),
		.resetn   (resetn),
		.restart  (mult_wr),
		.powered  (~disable_q),
		.done     (settle_done)
	);

	// a write in the cycle the count ends wins: the new ratio is not settled
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			lock_q <= 1'b0;
		end else if (mult_wr || disable_q) begin
			lock_q <= 1'b0;
		end else if (settle_done) begin
			lock_q <= 1'b1;
		end
	end

	// mode selection
	always_comb begin
		if (disable_q) begin
			mode_d = pll_clock_pkg::MODE_OFF;
		// a write drops to bypass at once, not a cycle after lock falls
		end else if (mult_wr || !lock_q
				|| mult_q == pll_clock_pkg::MULT_BYPASS) begin
			mode_d = pll_clock_pkg::MODE_BYPASS;
		end else begin
			mode_d = pll_clock_pkg::MODE_ENABLE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			mode_q <= pll_clock_pkg::MODE_BYPASS;
		end else begin
			mode_q <= mode_d;
		end
	end

	// multiplication seen by the cpu clock path; zero means none
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			eff_mult_q <= pll_clock_pkg::MULT_BYPASS;
		end else if (mode_d == pll_clock_pkg::MODE_ENABLE) begin
			eff_mult_q <= mult_q;
		end else begin
			eff_mult_q <= pll_clock_pkg::MULT_BYPASS;
		end
	end

	// bypass keeps the pll running, only off mode powers it down
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			powered_q <= 1'b1;
		end else begin
			powered_q <= ~disable_q;
		end
	end

	// reference ticks at oscillator over n, shared by every mode
	clk_halver u_halver (
		.core_clk (core_clk),
		.resetn   (resetn),
		.halve    (~halving_q),
		.tick     (ref_tick)
	);

	// the system clock output is the cpu clock passed back out
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cpu_tick_q <= 1'b0;
			sys_tick_q <= 1'b0;
		end else begin
			cpu_tick_q <= ref_tick;
			sys_tick_q <= ref_tick;
		end
	end

	// oscillator presence comes from the pad, two flops before use
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			osc_meta_q <= 1'b0;
			osc_sync_q <= 1'b0;
		end else begin
			osc_meta_q <= oscillator_present;
			osc_sync_q <= osc_meta_q;
		end
	end

	// limp mode is not promised from power-up, only after a good clock
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			osc_seen_q <= 1'b0;
		end else if (osc_sync_q) begin
			osc_seen_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			limp_q <= 1'b0;
		end else begin
			limp_q <= osc_seen_q & ~osc_sync_q
				& (mode_d != pll_clock_pkg::MODE_OFF);
		end
	end

	// read side
	always_comb begin
		status_word = '0;
		status_word[pll_clock_pkg::STS_LOCK_BIT]    = lock_q;
		status_word[pll_clock_pkg::STS_HALVING_BIT] = halving_q;
		status_word[pll_clock_pkg::STS_DISABLE_BIT] = disable_q;
	end

	always_comb begin
		unique case (reg_addr)
			pll_clock_pkg::OFF_CLKOUT_STATUS: begin
				rdata_d = clkout_status_q;
			end
			pll_clock_pkg::OFF_PLL_STATUS: begin
				rdata_d = status_word;
			end
			pll_clock_pkg::OFF_FAST_PRESCALE: begin
				rdata_d = fast_prescale_q;
			end
			pll_clock_pkg::OFF_SLOW_PRESCALE: begin
				rdata_d = slow_prescale_q;
			end
			pll_clock_pkg::OFF_CLK_GATE_0: begin
				rdata_d = clk_gate0_q;
			end
			pll_clock_pkg::OFF_CLK_GATE_1: begin
				rdata_d = clk_gate1_q;
			end
			pll_clock_pkg::OFF_PLL_MULT: begin
				rdata_d = {12'h000, mult_q};
			end
			default: begin
				rdata_d = 16'h0000;
			end
		endcase
	end

	// data stand only in the cycle after the read strobe
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rdata_q <= 16'h0000;
		end else if (reg_rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	assign reg_rdata                 = rdata_q;
	assign pll_mode                  = mode_q;
	assign pll_multiplier            = eff_mult_q;
	assign core_halving_select       = halving_q;
	assign pll_powered               = powered_q;
	assign pll_lock_flag             = lock_q;
	assign cpu_input_clock_en        = cpu_tick_q;
	assign system_clock_output_en    = sys_tick_q;
	assign limp_select               = limp_q;
	assign fast_peripheral_prescaler = fast_prescale_q;
	assign slow_peripheral_prescaler = slow_prescale_q;
	assign peripheral_clock_gate_0   = clk_gate0_q;
	assign peripheral_clock_gate_1   = clk_gate1_q;

endmodule

`default_nettype wire

// ===== inc/pll_clock_pkg.sv
package pll_clock_pkg;

	// register offsets on the 16-bit register port
	localparam logic [15:0] OFF_CLKOUT_STATUS = 16'h7010;
	localparam logic [15:0] OFF_PLL_STATUS    = 16'h7011;
	localparam logic [15:0] OFF_FAST_PRESCALE = 16'h701a;
	localparam logic [15:0] OFF_SLOW_PRESCALE = 16'h701b;
	localparam logic [15:0] OFF_CLK_GATE_0    = 16'h701c;
	localparam logic [15:0] OFF_CLK_GATE_1    = 16'h701d;
	localparam logic [15:0] OFF_PLL_MULT      = 16'h7021;

	// pll_status field positions
	localparam int unsigned STS_LOCK_BIT    = 0;
	localparam int unsigned STS_HALVING_BIT = 1;
	localparam int unsigned STS_DISABLE_BIT = 2;

	// multiplier field
	localparam int unsigned MULT_W = 4;
	localparam logic [3:0]  MULT_BYPASS = 4'h0;
	localparam logic [3:0]  MULT_MAX    = 4'ha;

	// reset values
	localparam logic [15:0] RST_WORD    = 16'h0000;
	localparam logic [3:0]  RST_MULT    = 4'h0;
	localparam logic        RST_HALVING = 1'b0;
	localparam logic        RST_DISABLE = 1'b0;

	// oscillator cycles from a multiplier write to lock
	localparam int unsigned PLL_SETTLE_CYCLES = 131072;

	typedef enum logic [1:0] {
		MODE_OFF    = 2'b00,
		MODE_BYPASS = 2'b01,
		MODE_ENABLE = 2'b10
	} pll_mode_t;

endpackage

// ===== core/clk_halver.sv
`timescale 1ns/1ps
`default_nettype none

// one-cycle ticks at the oscillator rate divided by one or two
module clk_halver (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic resetn,
	// divide select: high divides by two
	input  wire logic halve,
	// tick output
	output logic      tick
);

	logic phase_q;
	logic tick_q;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			phase_q <= 1'b0;
		end else if (halve) begin
			phase_q <= ~phase_q;
		end else begin
			phase_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= ~halve | phase_q;
		end
	end

	assign tick = tick_q;

endmodule

`default_nettype wire

// ===== core/pll_settle_timer.sv
`timescale 1ns/1ps
`default_nettype none

// counts the settle time after each restart while powered; done pulses once at the end
module pll_settle_timer #(
	parameter int unsigned CYCLES = pll_clock_pkg::PLL_SETTLE_CYCLES
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic resetn,
	// control
	input  wire logic restart,
	input  wire logic powered,
	// status
	output logic      done
);

	localparam int unsigned CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count_q;
	logic          running_q;
	logic          done_q;

	always_ff @(posedge core_clk) begin
		if (!resetn || !powered) begin
			running_q <= 1'b0;
			count_q   <= '0;
		end else if (restart) begin
			running_q <= 1'b1;
			count_q   <= '0;
		end else if (running_q) begin
			if (count_q == LAST) begin
				running_q <= 1'b0;
			end
			count_q <= count_q + 1'b1;
		end
	end

	// a restart in the final cycle discards the old count
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			done_q <= 1'b0;
		end else begin
			done_q <= powered & running_q & ~restart & (count_q == LAST);
		end
	end

	assign done = done_q;

endmodule

`default_nettype wire

// ===== test/pll_clock_props.sv
`timescale 1ns/1ps
`default_nettype none

module pll_clock_props #(
	parameter int unsigned SETTLE_CYCLES = 16
) (
	// clock, reset and register port
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        write_protect_override,
	input wire logic [15:0] fast_peripheral_prescaler,
	// clock control
	input wire logic        oscillator_present,
	input wire logic [1:0]  pll_mode,
	input wire logic [3:0]  pll_multiplier,
	input wire logic        core_halving_select,
	input wire logic        pll_powered,
	input wire logic        pll_lock_flag,
	input wire logic        cpu_input_clock_en,
	input wire logic        system_clock_output_en,
	input wire logic        limp_select
);
	localparam logic [1:0] ENA = pll_clock_pkg::MODE_ENABLE;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic        mult_wr;
	logic        fast_wr;
	logic [31:0] since_q;

	assign fast_wr = reg_wr && reg_addr == pll_clock_pkg::OFF_FAST_PRESCALE;
	assign mult_wr = reg_wr && write_protect_override
		&& reg_addr == pll_clock_pkg::OFF_PLL_MULT
		&& reg_wdata[3:0] <= pll_clock_pkg::MULT_MAX;

	// reserved codes are refused, so they must not restart this count
	always_ff @(posedge core_clk) begin
		if (!resetn || mult_wr) begin
			since_q <= 32'h0000_0000;
		end else if (since_q != 32'hffff_ffff) begin
			since_q <= since_q + 32'h0000_0001;
		end
	end

	AST_RESET_BYPASS:
	assert property ($rose(resetn) |-> pll_mode == pll_clock_pkg::MODE_BYPASS
		&& pll_multiplier == 4'h0 && !pll_lock_flag) else $error("reset mode");
	AST_TICK_MIRROR:
	assert property (system_clock_output_en == cpu_input_clock_en)
		else $error("clock output differs");
	AST_HALVE_ONE:
	assert property (core_halving_select [*3] |-> cpu_input_clock_en)
		else $error("tick missing at n=1");
	AST_HALVE_TWO:
	assert property ((!core_halving_select) [*3] ##0 cpu_input_clock_en
		|=> !cpu_input_clock_en) else $error("double tick at n=2");
	AST_BYPASS_MULT:
	assert property (pll_mode != ENA |-> pll_multiplier == 4'h0)
		else $error("multiplier outside enable");
	AST_ENABLE_LOCKED:
	assert property (pll_mode == ENA |-> pll_lock_flag && pll_multiplier != 4'h0
		&& pll_multiplier <= pll_clock_pkg::MULT_MAX) else $error("bad enable");
	AST_WRITE_RELOCK:
	assert property (mult_wr |=> !pll_lock_flag && pll_mode != ENA)
		else $error("no bypass after write");
	AST_LOCK_TIME:
	assert property ($rose(pll_lock_flag) |-> since_q + 32'h1 >= SETTLE_CYCLES
		&& since_q <= SETTLE_CYCLES + 3) else $error("lock time");
	AST_WP_IGNORE:
	assert property (fast_wr && !write_protect_override
		|=> $stable(fast_peripheral_prescaler)) else $error("guarded write");
	AST_WP_TAKE:
	assert property (fast_wr && write_protect_override
		|=> fast_peripheral_prescaler == $past(reg_wdata)) else $error("write");
	AST_OFF_MODE:
	assert property ((!pll_powered) [*2] |-> pll_mode == pll_clock_pkg::MODE_OFF
		&& !pll_lock_flag) else $error("off mode");
	AST_NO_LIMP:
	assert property (oscillator_present [*5] |-> !limp_select)
		else $error("limp with oscillator");
endmodule

`default_nettype wire

// ===== test/osc_source.sv
`timescale 1ns/1ps
`default_nettype none

// a starting oscillator shows only after warming up; a stop shows at once
module osc_source #(
	parameter int unsigned STARTUP = 4
) (
	// clock and control
	input  wire logic core_clk,
	input  wire logic run,
	// pad level
	output logic      present
);
	logic [7:0] warm_q;

	always_ff @(posedge core_clk) begin
		if (!run) begin
			warm_q  <= 8'h00;
			present <= 1'b0;
		end else if (warm_q < 8'(STARTUP)) begin
			warm_q  <= warm_q + 8'h01;
		end else begin
			present <= 1'b1;
		end
	end
endmodule

`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
	begin \
		n_compared++; \
		if ((g) !== (e)) begin \
			err_count++; \
			$display("[ERR] %s expected %h seen %h", nm, e, g); \
		end \
	end

module testbench;
	localparam int unsigned SETTLE = 16;
	localparam logic [15:0] STS = pll_clock_pkg::OFF_PLL_STATUS;
	localparam logic [15:0] MUL = pll_clock_pkg::OFF_PLL_MULT;
	localparam logic [1:0]  BYP = pll_clock_pkg::MODE_BYPASS;

	logic        core_clk, resetn, reg_wr, reg_rd, osc_run;
	logic        write_protect_override, oscillator_present;
	logic [15:0] reg_addr, reg_wdata, reg_rdata;
	logic [1:0]  pll_mode;
	logic [3:0]  pll_multiplier;
	logic        core_halving_select, pll_powered, pll_lock_flag;
	logic        cpu_input_clock_en, system_clock_output_en, limp_select;
	logic [15:0] fast_peripheral_prescaler, slow_peripheral_prescaler;
	logic [15:0] peripheral_clock_gate_0, peripheral_clock_gate_1;
	logic [15:0] plain [5];
	logic [15:0] vals [5];
	int          err_count, n_compared, seed, k, n;

	pll_clock_module #(.SETTLE_CYCLES(SETTLE)) i_pll_clock_module (
		.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .write_protect_override, .oscillator_present,
		.pll_mode, .pll_multiplier, .core_halving_select, .pll_powered,
		.pll_lock_flag, .cpu_input_clock_en, .system_clock_output_en,
		.limp_select, .fast_peripheral_prescaler, .slow_peripheral_prescaler,
		.peripheral_clock_gate_0, .peripheral_clock_gate_1
	);
	osc_source i_osc_source (.core_clk, .run(osc_run),
		.present(oscillator_present));

	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;

	// reserved codes leave the multiplier as it was
	function automatic logic [3:0] exp_mult(input logic [3:0] m, old);
		return (m > pll_clock_pkg::MULT_MAX) ? old : m;
	endfunction

	task automatic wr(input logic [15:0] a, d, input logic o);
		@(posedge core_clk);
		reg_addr               <= a;
		reg_wdata              <= d;
		write_protect_override <= o;
		reg_wr                 <= 1'b1;
		@(posedge core_clk);
		reg_wr                 <= 1'b0;
	endtask

	task automatic rdc(input logic [15:0] a, e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1;
		`CHK("rdata", e, reg_rdata)
	endtask

	task automatic ticks(input logic h);
		n = 0;
		repeat (8) begin
			@(posedge core_clk);
			#1;
			n += cpu_input_clock_en;
		end
		`CHK("ticks", h ? 8 : 4, n)
	endtask

	task automatic relock(input logic [3:0] m);
		// the block holds no watchdog, so there is none to stop first
		wr(MUL, {12'h000, m}, 1'b1);
		#1;
		`CHK("lock_clear", 1'b0, pll_lock_flag)
		`CHK("bypass", BYP, pll_mode)
		k = 1;
		while (pll_lock_flag !== 1'b1 && k < 200) begin
			@(posedge core_clk);
			#1;
			k++;
		end
		`CHK("settle", 1'b1, k >= SETTLE && k <= SETTLE + 4)
		@(posedge core_clk);
		#1;
		`CHK("mode", m == 4'h0 ? BYP : pll_clock_pkg::MODE_ENABLE, pll_mode)
		`CHK("mult", m, pll_multiplier)
	endtask

	task automatic wrap_up;
		$display("compared %0d mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		seed = 32'h7894;
		{resetn, reg_wr, reg_rd, write_protect_override} = 4'h0;
		{reg_addr, reg_wdata} = 32'h0;
		osc_run = 1'b0;
		plain = '{16'h7010, 16'h701a, 16'h701b, 16'h701c, 16'h701d};
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		osc_run <= 1'b1;
		@(posedge core_clk);
		#1;
		`CHK("mode", BYP, pll_mode)
		`CHK("powered", 1'b1, pll_powered)
		`CHK("limp_start", 1'b0, limp_select)
		foreach (plain[i]) rdc(plain[i], 16'h0000);
		rdc(MUL, 16'h0000);
		$display("test reset done");
		foreach (plain[i]) begin
			vals[i] = 16'($random(seed));
			wr(plain[i], vals[i], 1'b1);
			wr(plain[i], ~vals[i], 1'b0);
			rdc(plain[i], vals[i]);
		end
		`CHK("gate1", vals[4], peripheral_clock_gate_1)
		`CHK("fast", vals[1], fast_peripheral_prescaler)
		`CHK("slow", vals[2], slow_peripheral_prescaler)
		`CHK("gate0", vals[3], peripheral_clock_gate_0)
		wr(16'h7012, 16'hffff, 1'b1);
		rdc(16'h7012, 16'h0000);
		$display("test registers done");
		wr(STS, 16'h0000, 1'b1);
		for (int m = 1; m <= 10; m++) relock(4'(m));
		for (int m = 11; m <= 15; m++) begin
			wr(MUL, 16'(m), 1'b1);
			#1;
			`CHK("reserved", exp_mult(4'(m), 4'ha), pll_multiplier)
			`CHK("kept_lock", 1'b1, pll_lock_flag)
		end
		wr(MUL, 16'h0003, 1'b0);
		#1;
		`CHK("guarded", 1'b1, pll_lock_flag)
		rdc(MUL, 16'h000a);
		rdc(STS, 16'h0001);
		$display("test multiplier done");
		ticks(1'b0);
		wr(STS, 16'h0002, 1'b1);
		#1;
		`CHK("halving", 1'b1, core_halving_select)
		repeat (3) @(posedge core_clk);
		ticks(1'b1);
		wr(STS, 16'h0000, 1'b1);
		relock(4'h0);
		ticks(1'b0);
		// halving is set while locked, then kept through the power-down
		wr(STS, 16'h0002, 1'b1);
		wr(STS, 16'h0006, 1'b1);
		rdc(STS, 16'h0006);
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("off", pll_clock_pkg::MODE_OFF, pll_mode)
		`CHK("unpowered", 1'b0, pll_powered)
		ticks(1'b1);
		wr(STS, 16'h0004, 1'b1);
		ticks(1'b0);
		wr(STS, 16'h0000, 1'b1);
		$display("test modes done");
		@(posedge core_clk);
		osc_run <= 1'b0;
		k = 0;
		while (limp_select !== 1'b1 && k < 8) begin
			@(posedge core_clk);
			#1;
			k++;
		end
		`CHK("limp", 1'b1, limp_select)
		@(posedge core_clk);
		osc_run <= 1'b1;
		repeat (12) @(posedge core_clk);
		#1;
		`CHK("no_limp", 1'b0, limp_select)
		$display("test limp done");
		relock(4'(($random(seed) & 7) + 1));
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		#1;
		`CHK("mode", BYP, pll_mode)
		`CHK("mult", 4'h0, pll_multiplier)
		rdc(MUL, 16'h0000);
		$display("test reset again done");
		wrap_up();
	end

	initial begin
		#30000;
		err_count++;
		$display("[ERR] watchdog expected end seen hang");
		wrap_up();
	end
endmodule

bind pll_clock_module pll_clock_props #(
	.SETTLE_CYCLES(SETTLE_CYCLES)
) i_pll_clock_props (
	.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
	.write_protect_override, .fast_peripheral_prescaler, .oscillator_present,
	.pll_mode, .pll_multiplier, .core_halving_select, .pll_powered,
	.pll_lock_flag, .cpu_input_clock_en, .system_clock_output_en, .limp_select
);

`default_nettype wire
